// *** logic/spi_width_pin.sv ***
// Width and pin control register of a serial peripheral block, with a small shift engine.
//
// Implementation choice: the Wishbone interface to the registers.
`include "spi_width_pin_regs.svh"

// Behaviour
// - Width bit at 0 selects 8-bit transfers using only the low data byte.
// - Width bit at 1 joins both data bytes into one 16-bit transfer.
// - As master, changing width, fault enable or pin control aborts to idle.
// - Master with fault enable 0 ignores the select pin completely.
// - Master with fault enable 1 and select enable 0 watches the select pin and detects mode faults.
// - A slave uses the select pin only as an input.
// - In bidirectional mode the output enable bit gates the data output buffer.
// - Master with pin control set aborts when the output enable bit changes.
// - Clock stop bit 1 halts serial clock generation during wait mode.
// - Pin control 0 gives normal pins: master drives MOSI, slave drives MISO.
// - Bidirectional master leaves MISO unused and uses MOSI as data pin.
// - Bidirectional slave leaves MOSI unused and uses MISO as data pin.
// - Control register is always accessible; reserved bits ignore writes.
// - Select output works only as master with fault enable and select enable.
module spi_width_pin (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic waitMode,
  output logic irq,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic ssIn,
  output logic ssOut,
  output logic select_output_enable,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe
);
  spi_width_pin_pkg::state_s s_r;
  spi_width_pin_pkg::state_s s_nxt;
  logic isMaster;
  logic wide;
  logic pinCtl;
  logic mode_fault_enable;
  logic bidir_output_enable;
  logic enabled;
  logic reqWr;
  logic reqRd;
  logic [7:0] ctrlNew;
  logic [7:0] modeNew;
  logic abortReq;
  logic ssLow;
  logic sckRise;
  logic sckFall;
  logic serialIn;
  logic [4:0] xferBits;

  assign isMaster = s_r.mode[`MODE_MASTER_BIT];
  assign enabled = s_r.mode[`MODE_ENABLE_BIT];
  assign wide = s_r.ctrl[`CTRL_WIDTH_BIT];
  assign pinCtl = s_r.ctrl[`CTRL_PIN_BIT];
  assign mode_fault_enable = s_r.ctrl[`CTRL_MODE_FAULT_FLAG_BIT];
  assign bidir_output_enable = s_r.ctrl[`CTRL_BIDIR_BIT];
  assign reqWr = cyc_i && stb_i && we_i && !s_r.ack;
  assign reqRd = cyc_i && stb_i && !we_i && !s_r.ack;
  assign ssLow = !s_r.ssSync[2] && !s_r.ssSync[1];
  assign sckRise = s_r.sckSync[1] && s_r.sckSync[2] && !s_r.sckLevel;
  assign sckFall = !s_r.sckSync[1] && !s_r.sckSync[2] && s_r.sckLevel;
  assign xferBits = wide ? 5'h10 : 5'h08;

  // ---------------------------------------------------------------
  // Pin steering
  // ---------------------------------------------------------------
  always_comb
  begin
    sckOut = s_r.sckLevel;
    sckOe = enabled && isMaster;
    select_output_enable = enabled && isMaster && mode_fault_enable && s_r.mode[`MODE_SELECT_OUTPUT_ENABLE_BIT];
    ssOut = (s_r.state == spi_width_pin_pkg::IDLE);
    mosiOe = enabled && isMaster && (!pinCtl || bidir_output_enable);
    misoOe = enabled && !isMaster && (!pinCtl || bidir_output_enable) && ssLow;
    mosiOut = wide ? s_r.shiftReg[15] : s_r.shiftReg[7];
    misoOut = mosiOut;
    if (isMaster)
    begin
      serialIn = pinCtl ? s_r.mosiSync[2] : s_r.misoSync[2];
    end
    else
    begin
      serialIn = pinCtl ? s_r.misoSync[2] : s_r.mosiSync[2];
    end
    dat_o = s_r.rdData;
    ack_o = s_r.ack;
    irq = |(s_r.irqStat & s_r.irqMask);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ssSync = {s_r.ssSync[1:0], ssIn};
    s_nxt.sckSync = {s_r.sckSync[1:0], sckIn};
    s_nxt.mosiSync = {s_r.mosiSync[1:0], mosiIn};
    s_nxt.misoSync = {s_r.misoSync[1:0], misoIn};
    s_nxt.ack = reqWr || reqRd;
    ctrlNew = s_r.ctrl;
    modeNew = s_r.mode;
    if (reqWr && sel_i[0] && adr_i == `CTRL_ADDR)
    begin
      ctrlNew = dat_i[7:0] & `CTRL_WMASK;
    end
    if (reqWr && sel_i[0] && adr_i == `MODE_ADDR)
    begin
      modeNew = dat_i[7:0] & 8'h07;
    end
    abortReq = (isMaster && (s_r.state != spi_width_pin_pkg::IDLE) &&
      (((ctrlNew ^ s_r.ctrl) & 8'h51) != 8'h00 ||
      (pinCtl && (ctrlNew[`CTRL_BIDIR_BIT] != bidir_output_enable)) ||
      (modeNew[1:0] != s_r.mode[1:0]))) || !modeNew[`MODE_ENABLE_BIT];
    s_nxt.ctrl = ctrlNew;
    s_nxt.mode = modeNew;
    if (reqWr && adr_i == `TXDATA_ADDR)
    begin
      if (sel_i[0])
      begin
        s_nxt.txData[7:0] = dat_i[7:0];
      end
      if (sel_i[1])
      begin
        s_nxt.txData[15:8] = dat_i[15:8];
      end
    end
    if (reqWr && adr_i == `IRQSTAT_ADDR && sel_i[0])
    begin
      s_nxt.irqStat = s_r.irqStat & ~dat_i[2:0];
    end
    if (reqWr && adr_i == `IRQMASK_ADDR && sel_i[0])
    begin
      s_nxt.irqMask = dat_i[2:0];
    end
    s_nxt.rdData = 32'h0000_0000;
    if (reqRd)
    begin
      unique case (adr_i)
        `CTRL_ADDR: s_nxt.rdData = {24'h00_0000, s_r.ctrl};
        `MODE_ADDR: s_nxt.rdData = {24'h00_0000, s_r.mode};
        `TXDATA_ADDR: s_nxt.rdData = {16'h0000, s_r.txData};
        `RXDATA_ADDR: s_nxt.rdData = {16'h0000, wide ? s_r.rxData[15:8] : 8'h00,
          s_r.rxData[7:0]};
        `STATUS_ADDR: s_nxt.rdData = {29'h0000_0000, s_r.modeFault,
          s_r.state != spi_width_pin_pkg::IDLE, waitMode};
        `IRQSTAT_ADDR: s_nxt.rdData = {29'h0000_0000, s_r.irqStat};
        `IRQMASK_ADDR: s_nxt.rdData = {29'h0000_0000, s_r.irqMask};
        default: s_nxt.rdData = 32'h0000_0000;
      endcase
    end
    // Master fault: another party pulled select low while we drive the bus.
    if (enabled && isMaster && mode_fault_enable && !s_r.mode[`MODE_SELECT_OUTPUT_ENABLE_BIT] && ssLow)
    begin
      s_nxt.modeFault = 1'b1;
      s_nxt.irqStat[`IRQ_FAULT_BIT] = 1'b1;
      s_nxt.mode[`MODE_MASTER_BIT] = 1'b0;
      s_nxt.state = spi_width_pin_pkg::IDLE;
      s_nxt.sckLevel = 1'b0;
    end
    else if (abortReq)
    begin
      if (s_r.state != spi_width_pin_pkg::IDLE)
      begin
        s_nxt.irqStat[`IRQ_ABORT_BIT] = 1'b1;
      end
      s_nxt.state = spi_width_pin_pkg::IDLE;
      s_nxt.sckLevel = 1'b0;
    end
    else
    begin
      unique case (s_r.state)
        spi_width_pin_pkg::IDLE:
        begin
          s_nxt.bitCnt = 5'h00;
          s_nxt.divCnt = 8'h00;
          if (isMaster && reqWr && adr_i == `TXDATA_ADDR)
          begin
            s_nxt.shiftReg = {sel_i[1] ? dat_i[15:8] : s_r.txData[15:8],
              sel_i[0] ? dat_i[7:0] : s_r.txData[7:0]};
            s_nxt.state = spi_width_pin_pkg::SHIFT;
          end
          else if (!isMaster && ssLow)
          begin
            s_nxt.shiftReg = s_r.txData;
            s_nxt.sckLevel = s_r.sckSync[2];
            s_nxt.state = spi_width_pin_pkg::SHIFT;
          end
        end
        spi_width_pin_pkg::SHIFT:
        begin
          if (isMaster)
          begin
            if (!(waitMode && s_r.ctrl[`CTRL_SWAI_BIT]))
            begin
              if (s_r.divCnt == 8'(`HALF_CYCLES - 1))
              begin
                s_nxt.divCnt = 8'h00;
                s_nxt.sckLevel = !s_r.sckLevel;
                if (!s_r.sckLevel)
                begin
                  s_nxt.rxData = {s_r.rxData[14:0], serialIn};
                  s_nxt.bitCnt = s_r.bitCnt + 5'h01;
                end
                else
                begin
                  s_nxt.shiftReg = {s_r.shiftReg[14:0], 1'b0};
                  if (s_r.bitCnt == xferBits)
                  begin
                    s_nxt.state = spi_width_pin_pkg::DONE;
                  end
                end
              end
              else
              begin
                s_nxt.divCnt = s_r.divCnt + 8'h01;
              end
            end
          end
          else if (!ssLow)
          begin
            s_nxt.state = spi_width_pin_pkg::IDLE;
          end
          else if (sckRise)
          begin
            s_nxt.sckLevel = 1'b1;
            s_nxt.rxData = {s_r.rxData[14:0], serialIn};
            s_nxt.bitCnt = s_r.bitCnt + 5'h01;
          end
          else if (sckFall)
          begin
            s_nxt.sckLevel = 1'b0;
            s_nxt.shiftReg = {s_r.shiftReg[14:0], 1'b0};
            if (s_r.bitCnt == xferBits)
            begin
              s_nxt.state = spi_width_pin_pkg::DONE;
            end
          end
        end
        spi_width_pin_pkg::DONE:
        begin
          s_nxt.irqStat[`IRQ_DONE_BIT] = 1'b1;
          s_nxt.state = isMaster || !ssLow ? spi_width_pin_pkg::IDLE :
            spi_width_pin_pkg::DONE;
        end
        default: s_nxt.state = spi_width_pin_pkg::IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_reserved_bits: assert property (@(posedge clk) disable iff (!arst_n)
    (s_r.ctrl & ~`CTRL_WMASK) == 8'h00) else $error("reserved control bit set");
  a_narrow_high: assert property (@(posedge clk) disable iff (!arst_n)
    (reqRd && adr_i == `RXDATA_ADDR && !wide) |=> dat_o[15:8] == 8'h00)
    else $error("high byte visible in narrow mode");
  a_wide_high: assert property (@(posedge clk) disable iff (!arst_n)
    (reqRd && adr_i == `RXDATA_ADDR && wide) |=> dat_o[15:8] == $past(s_r.rxData[15:8]))
    else $error("high byte lost in wide mode");
  a_abort_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (isMaster && s_r.state == spi_width_pin_pkg::SHIFT && reqWr && sel_i[0] &&
    adr_i == `CTRL_ADDR && ((dat_i[7:0] ^ s_r.ctrl) & 8'h51) != 8'h00)
    |=> s_r.state == spi_width_pin_pkg::IDLE) else $error("no abort on width change");
  a_bidir_abort: assert property (@(posedge clk) disable iff (!arst_n)
    (isMaster && pinCtl && s_r.state == spi_width_pin_pkg::SHIFT && reqWr && sel_i[0] &&
    adr_i == `CTRL_ADDR && dat_i[3] != bidir_output_enable) |=> s_r.state == spi_width_pin_pkg::IDLE)
    else $error("no abort on output enable change");
  a_no_ss_use: assert property (@(posedge clk) disable iff (!arst_n)
    (isMaster && !mode_fault_enable) |-> !select_output_enable && $stable(s_r.modeFault)) else $error("select used");
  a_slave_ss: assert property (@(posedge clk) disable iff (!arst_n)
    !isMaster |-> !select_output_enable) else $error("slave drives select");
  a_pin_buffers: assert property (@(posedge clk) disable iff (!arst_n)
    (enabled && pinCtl && !bidir_output_enable) |-> !mosiOe && !misoOe) else $error("buffer on");
  a_wait_stop: assert property (@(posedge clk) disable iff (!arst_n)
    (isMaster && waitMode && s_r.ctrl[1] && $past(waitMode && s_r.ctrl[1]))
    |-> $stable(sckOut)) else $error("clock runs in wait");
endmodule : spi_width_pin

// *** shared/spi_width_pin_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the width and pin block.
`ifndef SPI_WIDTH_PIN_REGS_SVH
`define SPI_WIDTH_PIN_REGS_SVH
`define CTRL_IDX 4'h1
`define CTRL_ADDR 6'h04
`define MODE_ADDR 6'h00
`define TXDATA_ADDR 6'h10
`define RXDATA_ADDR 6'h14
`define STATUS_ADDR 6'h18
`define IRQSTAT_ADDR 6'h1C
`define IRQMASK_ADDR 6'h20
`define CTRL_WIDTH_BIT 6
`define CTRL_MODE_FAULT_FLAG_BIT 4
`define CTRL_BIDIR_BIT 3
`define CTRL_SWAI_BIT 1
`define CTRL_PIN_BIT 0
`define CTRL_WMASK 8'h5B
`define CTRL_RESET 8'h00
`define MODE_MASTER_BIT 0
`define MODE_SELECT_OUTPUT_ENABLE_BIT 1
`define MODE_ENABLE_BIT 2
`define MODE_RESET 8'h00
`define IRQ_DONE_BIT 0
`define IRQ_FAULT_BIT 1
`define IRQ_ABORT_BIT 2
`define HALF_PERIOD_NS 100
`define CLK_PERIOD_NS 25
`define HALF_CYCLES (`HALF_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// *** shared/spi_width_pin_pkg.sv ***
// Types shared by the width and pin block.
package spi_width_pin_pkg;
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    SHIFT = 2'b01,
    DONE = 2'b10
  } xfer_e;
  typedef struct packed {
    xfer_e state;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [15:0] txData;
    logic [15:0] rxData;
    logic [15:0] shiftReg;
    logic [4:0] bitCnt;
    logic [7:0] divCnt;
    logic sckLevel;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic modeFault;
    logic [2:0] ssSync;
    logic [2:0] sckSync;
    logic [2:0] mosiSync;
    logic [2:0] misoSync;
    logic [31:0] rdData;
    logic ack;
  } state_s;
endpackage : spi_width_pin_pkg

// *** sim/spi_partner_model.sv ***
// Serial slave model that answers master transfers of the block.
module spi_partner_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic load,
  input wire logic [15:0] loadVal,
  output logic miso,
  output logic [15:0] rxShift
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] txShift;
  // The model presents its next bit before the master samples it.
  assign miso = txShift[15];
  always @(posedge sck or posedge load)
  begin
    if (load) rxShift <= 16'h0000;
    else rxShift <= {rxShift[14:0], mosi};
  end
  always @(negedge sck or posedge load)
  begin
    if (load) txShift <= loadVal;
    else txShift <= {txShift[14:0], ~txShift[0]};
  end
endmodule : spi_partner_model

// *** sim/tb_spi_width_pin.sv ***
// Self-checking bench of the width and pin block.
`include "spi_width_pin_regs.svh"
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_spi_width_pin;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arstN = 0, we = 0, cyc = 0, stb = 0, ack, irq, waitMode = 0;
  logic [5:0] adr = 6'h00;
  logic [31:0] datI = 32'h0, datO, rd;
  logic [3:0] sel = 4'h0;
  logic sckOut, sckOe, ssOut, select_output_enable, mosiOut, mosiOe, misoOut, misoOe;
  logic ssLine = 1, ld = 0, pMiso;
  logic [15:0] ldVal = 16'h0, pRx;
  int seed = 32'h68E9A784, errCount = 0, totalChecks = 0, sckEdges = 0;
  logic sckPrev = 0;
  logic [7:0] ca [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] cb [4] = '{8'h40, 8'h10, 8'h01, 8'h09};
  wire sckW = sckOe ? sckOut : 1'b0;
  always #12.5 clk = ~clk;
  spi_width_pin u_dut (.clk(clk), .arst_n(arstN), .adr_i(adr), .dat_i(datI), .dat_o(datO),
    .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .waitMode(waitMode),
    .irq(irq), .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe), .ssIn(select_output_enable ? ssOut : ssLine),
    .ssOut(ssOut), .select_output_enable(select_output_enable), .mosiIn(mosiOe ? mosiOut : 1'b1), .mosiOut(mosiOut),
    .mosiOe(mosiOe), .misoIn(misoOe ? misoOut : pMiso), .misoOut(misoOut), .misoOe(misoOe));
  spi_partner_model u_peer (.sck(sckW), .mosi(mosiOut), .load(ld), .loadVal(ldVal),
    .miso(pMiso), .rxShift(pRx));
  always @(posedge clk)
  begin
    sckPrev <= sckOut;
    if (sckOut && !sckPrev) sckEdges++;
  end
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a; datI <= d; we <= w; sel <= 4'hF; cyc <= 1; stb <= 1;
    do @(posedge clk); while (ack !== 1'b1);
    rd = datO;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask : wb
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  function automatic logic [15:0] expRx(input logic [15:0] v, input logic w);
    return w ? v : {8'h00, v[15:8]};
  endfunction : expRx
  task automatic xfer(input logic w, input logic [7:0] extra, input logic hold);
    logic [15:0] tx, m;
    int i;
    tx = 16'($random(seed));
    m = w ? 16'hFFFF : 16'h00FF;
    wb(1, `CTRL_ADDR, {24'h0, extra | (w ? 8'h40 : 8'h00)});
    wb(1, `IRQSTAT_ADDR, 32'h7);
    @(posedge clk);
    ldVal <= 16'($random(seed));
    ld <= 1;
    @(posedge clk);
    ld <= 0;
    sckEdges = 0;
    wb(1, `TXDATA_ADDR, {16'h0, tx});
    if (hold)
    begin
      idle(200);
      `CHK("stopped", 0, sckEdges)
      @(posedge clk);
      waitMode <= 0;
    end
    for (i = 0; i < 2000 && irq !== 1'b1; i++) @(negedge clk);
    `CHK("bits", w ? 16 : 8, sckEdges)
    wb(0, `RXDATA_ADDR, 32'h0);
    `CHK("rx", expRx(ldVal, w) & m, rd[15:0] & m)
    `CHK("wire", tx & m, pRx & m)
    wb(1, `IRQSTAT_ADDR, 32'h1);
    `CHK("irqClr", 1'b0, irq)
  endtask : xfer
  task automatic conclude;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial
  begin
    #1500000;
    errCount++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    arstN <= 1;
    wb(0, `CTRL_ADDR, 32'h0);
    `CHK("ctrlRst", 32'(`CTRL_RESET), rd)
    wb(1, `CTRL_ADDR, 32'hFF);
    wb(0, `CTRL_ADDR, 32'h0);
    `CHK("ctrlMask", 32'(`CTRL_WMASK), rd)
    wb(0, 6'h3C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb(1, `MODE_ADDR, 32'h5);
    wb(1, `IRQMASK_ADDR, 32'h7);
    xfer(0, 8'h00, 0);
    `CHK("ssOff", 1'b0, select_output_enable)
    `CHK("misoM", 1'b0, misoOe)
    xfer(1, 8'h00, 0);
    repeat (4) xfer(1'($random(seed)), 8'h00, 0);
    waitMode <= 1;
    xfer(1, 8'h00, 0);
    @(posedge clk);
    waitMode <= 1;
    xfer(0, 8'h02, 1);
    for (int k = 0; k < 4; k++)
    begin
      wb(1, `CTRL_ADDR, {24'h0, ca[k]});
      wb(1, `IRQSTAT_ADDR, 32'h7);
      sckEdges = 0;
      wb(1, `TXDATA_ADDR, 32'h0000A5C3);
      idle(40);
      wb(1, `CTRL_ADDR, {24'h0, cb[k]});
      idle(100);
      `CHK("cut", 1'b1, sckEdges < 8)
      wb(0, `STATUS_ADDR, 32'h0);
      `CHK("busy", 1'b0, rd[1])
      wb(0, `IRQSTAT_ADDR, 32'h0);
      `CHK("abort", 1'b1, rd[2])
    end
    `CHK("mosiOn", 1'b1, mosiOe)
    wb(1, `CTRL_ADDR, 32'h01);
    `CHK("mosiOff", 1'b0, mosiOe)
    wb(1, `IRQSTAT_ADDR, 32'h7);
    wb(1, `CTRL_ADDR, 32'h10);
    wb(1, `MODE_ADDR, 32'h7);
    `CHK("ssOut", 1'b1, select_output_enable)
    wb(1, `MODE_ADDR, 32'h5);
    `CHK("ssIn", 1'b0, select_output_enable)
    @(posedge clk);
    ssLine <= 0;
    idle(10);
    wb(0, `IRQSTAT_ADDR, 32'h0);
    `CHK("fault", 1'b1, rd[1])
    `CHK("irqSet", 1'b1, irq)
    wb(1, `IRQMASK_ADDR, 32'h0);
    `CHK("irqMask", 1'b0, irq)
    wb(1, `MODE_ADDR, 32'h6);
    `CHK("ssSlave", 1'b0, select_output_enable)
    wb(1, `CTRL_ADDR, 32'h09);
    `CHK("misoOn", 1'b1, misoOe)
    wb(1, `CTRL_ADDR, 32'h01);
    `CHK("misoOff", 1'b0, misoOe)
    `CHK("mosiS", 1'b0, mosiOe)
    conclude();
  end
endmodule : tb_spi_width_pin
